// ### hdl/pcs_por_seq.sv
// Power-on reset sequencer: reset pulse generation, strap capture, clock start.
// Assumes i_clk is the reference timing clock and runs during and after reset.
`timescale 1ns/10ps
module pcs_por_seq import pcs_pkg::*; #(
    parameter int RST_CYC = RST_PULSE_CYC,
    parameter int HOLD_CYC = BTN_HOLD_CYC,
    parameter int DIV_HALF = CORE_DIV_HALF
) (
    input wire logic i_clk,                  // Reference timing clock, 100 MHz
    input wire logic i_nrst,                 // Synchronous reset, active low
    input wire logic i_rail_ok,              // Supply comparator, high above threshold
    input wire logic i_chip_rst_line_n_i,    // Reset pin level as sensed
    output logic o_chip_rst_line_n_o,        // Reset pin drive value, always low
    output logic o_chip_rst_line_n_oe,       // Reset pin pull-down enable
    input wire logic i_ring_osc_strap,       // Oscillator strap one
    input wire logic i_internal_xtal_strap,  // Oscillator strap two
    input wire logic i_sink_cable_det,       // Monitor cable present, high
    output logic o_core_rst_n,               // Internal reset, active low
    output logic o_xtal_osc_en,              // Crystal oscillator enable
    output logic o_standby,                  // Low-power standby
    output logic o_core_clk                  // Derived internal clock
);
    localparam int CW = $clog2(RST_CYC + 1);
    localparam int DW = $clog2(DIV_HALF + 1);

    if (RST_CYC < 2 || HOLD_CYC < 1 || DIV_HALF < 1) begin : g_chk
        $error("pcs_por_seq: counts out of range");
    end

    pcs_state_t st_q;
    pcs_state_t st_d;
    logic [CW-1:0] cnt_q;
    logic [1:0] strap_s1_q;
    logic [1:0] strap_s2_q;
    logic cable_s1_q;
    logic cable_s2_q;
    logic core_rst_n_q;
    logic pin_oe_q;
    logic xtal_en_q;
    logic standby_q;
    logic [DW-1:0] div_q;
    logic core_clk_q;

    pcs_flt_if rail_f ();
    pcs_flt_if btn_f ();

    // ==========================================================
    // Event filters
    // Rail droop must persist past the glitch window
    assign rail_f.raw = i_rail_ok;
    assign rail_f.clr = 1'b0;
    pcs_lvl_filter #(.N_CYC(GLITCH_CYC), .ACT(1'b0)) u_rail_flt (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .f(rail_f)
    );

    // Our own pull-down reads back low, so the hold count only runs once released
    assign btn_f.raw = i_chip_rst_line_n_i;
    assign btn_f.clr = (st_q != S_RUN);
    pcs_lvl_filter #(.N_CYC(HOLD_CYC), .ACT(1'b0)) u_btn_flt (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .f(btn_f)
    );

    // Straps and cable detect cross in through two flops
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            strap_s1_q <= 2'h0;
            strap_s2_q <= 2'h0;
            cable_s1_q <= 1'b0;
            cable_s2_q <= 1'b0;
        end else begin
            strap_s1_q <= {i_ring_osc_strap, i_internal_xtal_strap};
            strap_s2_q <= strap_s1_q;
            cable_s1_q <= i_sink_cable_det;
            cable_s2_q <= cable_s1_q;
        end
    end

    // ==========================================================
    // Sequencer
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            st_q <= S_WAIT_RAIL;
        end else begin
            st_q <= st_d;
        end
    end

    // A droop outranks a manual hold; both restart the pulse from the top
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            S_WAIT_RAIL: begin
                if (rail_f.lvl) begin
                    st_d = S_PULSE;
                end
            end
            S_PULSE: begin
                if (rail_f.hit) begin
                    st_d = S_WAIT_RAIL;
                end else if (cnt_q == CW'(RST_CYC - 1)) begin
                    st_d = S_RUN;
                end
            end
            S_RUN: begin
                if (rail_f.hit) begin
                    st_d = S_WAIT_RAIL;
                end else if (btn_f.hit) begin
                    st_d = S_PULSE;
                end
            end
            default: st_d = S_WAIT_RAIL;
        endcase
    end

    // Pulse length counter, cleared whenever the pulse is not running
    always_ff @(posedge i_clk) begin
        if (!i_nrst || st_q != S_PULSE) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    // Pin pull-down and internal reset follow the same next state
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pin_oe_q <= PIN_OE_RST;
            core_rst_n_q <= 1'b0;
        end else begin
            pin_oe_q <= (st_d != S_RUN);
            core_rst_n_q <= (st_d == S_RUN);
        end
    end

    // ==========================================================
    // Straps and standby
    // Straps are re-sampled on every pulse cycle; the last sample is kept
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            xtal_en_q <= XTAL_EN_RST;
        end else if (st_q == S_PULSE) begin
            xtal_en_q <= ~|strap_s2_q;
        end
    end

    // Standby only outside reset, so a pulse always runs at full power
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            standby_q <= 1'b0;
        end else begin
            standby_q <= (st_d == S_RUN) && !cable_s2_q;
        end
    end

    // ==========================================================
    // Derived clock: stopped low in reset and standby to save power
    always_ff @(posedge i_clk) begin
        if (!i_nrst || !core_rst_n_q || standby_q) begin
            div_q <= '0;
            core_clk_q <= 1'b0;
        end else if (div_q == DW'(DIV_HALF - 1)) begin
            div_q <= '0;
            core_clk_q <= ~core_clk_q;
        end else begin
            div_q <= div_q + DW'(1);
        end
    end

    assign o_chip_rst_line_n_o = 1'b0;
    assign o_chip_rst_line_n_oe = pin_oe_q;
    assign o_core_rst_n = core_rst_n_q;
    assign o_xtal_osc_en = xtal_en_q;
    assign o_standby = standby_q;
    assign o_core_clk = core_clk_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    property p_rail_launch;
        st_q == S_WAIT_RAIL && rail_f.lvl |=> st_q == S_PULSE ##1 o_chip_rst_line_n_oe;
    endproperty
    a_rail_launch: assert property (p_rail_launch)
        else $error("rail good did not launch a pulse");

    property p_droop_reset;
        st_q == S_RUN && rail_f.hit |=> st_q == S_WAIT_RAIL && o_chip_rst_line_n_oe && !o_core_rst_n;
    endproperty
    a_droop_reset: assert property (p_droop_reset)
        else $error("long droop did not assert reset");

    property p_hold_reset;
        st_q == S_RUN && btn_f.hit && !rail_f.hit |=> st_q == S_PULSE && cnt_q == '0;
    endproperty
    a_hold_reset: assert property (p_hold_reset)
        else $error("manual hold did not restart the pulse");

    property p_pulse_len;
        $fell(o_chip_rst_line_n_oe) |-> $past(cnt_q) == CW'(RST_CYC - 1) && $past(st_q) == S_PULSE;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset pin released at the wrong count");

    property p_hold_in_reset;
        st_q != S_RUN |-> !o_core_rst_n && !o_standby ##1 !o_core_clk;
    endproperty
    a_hold_in_reset: assert property (p_hold_in_reset)
        else $error("logic not held during reset");

    property p_strap_sample;
        $rose(o_core_rst_n) |-> o_xtal_osc_en == ~|$past(strap_s2_q);
    endproperty
    a_strap_sample: assert property (p_strap_sample)
        else $error("oscillator enable does not match straps");

    property p_clk_run;
        core_rst_n_q && !standby_q && div_q == DW'(DIV_HALF - 1) |=> o_core_clk != $past(o_core_clk);
    endproperty
    a_clk_run: assert property (p_clk_run)
        else $error("derived clock failed to toggle");

    property p_standby;
        st_d == S_RUN |=> o_standby == !$past(cable_s2_q);
    endproperty
    a_standby: assert property (p_standby)
        else $error("cable loss did not enter standby");

    c_release: cover property (st_q == S_PULSE ##1 st_q == S_RUN);
    c_droop: cover property (st_q == S_RUN ##1 st_q == S_WAIT_RAIL);
    c_button: cover property (st_q == S_RUN && btn_f.hit);
    c_standby: cover property ($rose(o_standby) ##[1:300] $fell(o_standby));

endmodule

// ### hdl/pcs_pkg.sv
// Shared constants for the power-on reset, strap and clock-start sequencer.
// Assumes one 100 MHz clock; the pulse, hold and glitch times are turned into cycles here.
package pcs_pkg;

    // ==========================================================
    // Clock and unit figures
    localparam int CLK_PERIOD_NS = 32'h0000_000A;  // 10 ns
    localparam int NS_PER_MS = 32'h000F_4240;      // 1,000,000
    localparam int REF_CLK_KHZ = 32'h0000_6978;    // 27 MHz reference

    // ==========================================================
    // Documented times
    localparam int RST_PULSE_MS = 32'h0000_00A0;     // 160 ms nominal
    localparam int RST_PULSE_MIN_MS = 32'h0000_0096; // 150 ms
    localparam int RST_PULSE_MAX_MS = 32'h0000_00FA; // 250 ms
    localparam int BTN_HOLD_MS = 32'h0000_0001;      // 1 ms least
    localparam int GLITCH_NS = 32'h0000_0096;        // 150 ns

    // ==========================================================
    // Derived cycle counts (least times round up)
    localparam int RST_PULSE_CYC = RST_PULSE_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int BTN_HOLD_CYC = (BTN_HOLD_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CORE_DIV_HALF = 32'h0000_0002;    // Derived clock half period

    // ==========================================================
    // Reset values
    localparam logic PIN_OE_RST = 1'b1;
    localparam logic XTAL_EN_RST = 1'b0;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        S_WAIT_RAIL = 3'b001,
        S_PULSE = 3'b010,
        S_RUN = 3'b100
    } pcs_state_t;

endpackage

// ### hdl/pcs_flt_if.sv
// Carrier between the sequencer and one level filter.
// Assumes the raw level is asynchronous to the filter clock.
`timescale 1ns/10ps
interface pcs_flt_if;
    logic raw;  // Asynchronous level in
    logic clr;  // Restart the persistence count
    logic lvl;  // Synchronised level
    logic hit;  // Active level held long enough
    modport flt (input raw, input clr, output lvl, output hit);
    modport user (output raw, output clr, input lvl, input hit);
endinterface

// ### hdl/pcs_lvl_filter.sv
// Two-flop synchroniser followed by a persistence counter.
// Assumes i_clk runs free; raw may change at any time.
`timescale 1ns/10ps
module pcs_lvl_filter import pcs_pkg::*; #(
    parameter int N_CYC = GLITCH_CYC,
    parameter bit ACT = 1'b0
) (
    input wire logic i_clk,  // System clock
    input wire logic i_nrst, // Synchronous reset, active low
    pcs_flt_if.flt f         // Level in, filtered level out
);
    localparam int W = $clog2(N_CYC + 1);

    if (N_CYC < 1) begin : g_chk
        $error("pcs_lvl_filter: N_CYC must be at least 1");
    end

    logic s1_q;
    logic s2_q;
    logic [W-1:0] cnt_q;

    // ==========================================================
    // Synchroniser; first stage feeds only the second
    // Reset to the active level, so a false good level cannot follow reset
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            s1_q <= ACT;
            s2_q <= ACT;
        end else begin
            s1_q <= f.raw;
            s2_q <= s1_q;
        end
    end

    // Consecutive active cycles, saturating so a long hold stays hit
    always_ff @(posedge i_clk) begin
        if (!i_nrst || f.clr || s2_q != ACT) begin
            cnt_q <= '0;
        end else if (cnt_q != W'(N_CYC)) begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    assign f.lvl = s2_q;
    assign f.hit = (cnt_q == W'(N_CYC));

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    property p_hit_needs_level;
        $rose(f.hit) |-> $past(s2_q) == ACT && !$past(f.clr);
    endproperty
    a_hit_needs_level: assert property (p_hit_needs_level)
        else $error("filter hit without a held active level");

endmodule

// ### sim/pcs_far_side.sv
// Far-side model: supply monitor, reset push-button, straps and cable.
// Assumes the bench gives commands; the reset pin has a pull-up.
`timescale 1ns/10ps
module pcs_far_side (
    input wire logic i_clk,             // Reference clock
    input wire logic i_rail_cmd,        // Rail above threshold
    input wire logic i_btn_cmd,         // Button pressed
    input wire logic [1:0] i_strap_cmd, // Strap levels
    input wire logic i_cable_cmd,       // Cable attached
    input wire logic i_pin_oe,          // Device pull-down on
    output logic o_rail_ok,             // Comparator output
    output logic o_pin_lvl,             // Reset pin level
    output logic [1:0] o_strap,         // Strap pins
    output logic o_cable                // Sink detect
);
    // ====================
    // Levels move only at the clock edge, so no race with the sampler
    logic rail_q = 1'b0;
    logic btn_q = 1'b0;
    logic [1:0] strap_q = 2'h0;
    logic cable_q = 1'b1;
    always @(posedge i_clk) begin
        rail_q <= i_rail_cmd;
        btn_q <= i_btn_cmd;
        strap_q <= i_strap_cmd;
        cable_q <= i_cable_cmd;
    end
    // Open-drain pin: anyone pulling wins, pull-up otherwise
    assign o_pin_lvl = !(i_pin_oe || btn_q);
    assign o_rail_ok = rail_q;
    assign o_strap = strap_q;
    assign o_cable = cable_q;
endmodule

// ### sim/tb.sv
// Self-checking bench for the power-on reset sequencer.
// Assumes short sim counts; the far side is driven through pcs_far_side.
`timescale 1ns/10ps
module tb;
    import pcs_pkg::*;
    localparam int RC = 20;
    localparam int HC = 8;
    localparam int DH = 2;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic rail_c = 1'b0;
    logic btn_c = 1'b0;
    logic [1:0] strap_c = 2'h0;
    logic cable_c = 1'b1;
    logic rail, pin, cable, oe, po, crn, xen, sby, cclk, pv;
    logic [1:0] strap;
    int fails = 0;
    int tests_run = 0;
    int seed = 99;
    int cyc = 0;
    int n, s, r;
    // ====================
    // Clock runs free through and after reset
    always #5 clk = ~clk;
    pcs_far_side i_far (.i_clk(clk), .i_rail_cmd(rail_c), .i_btn_cmd(btn_c),
        .i_strap_cmd(strap_c), .i_cable_cmd(cable_c), .i_pin_oe(oe),
        .o_rail_ok(rail), .o_pin_lvl(pin), .o_strap(strap), .o_cable(cable));
    pcs_por_seq #(.RST_CYC(RC), .HOLD_CYC(HC), .DIV_HALF(DH)) i_dut (
        .i_clk(clk), .i_nrst(nrst), .i_rail_ok(rail), .i_chip_rst_line_n_i(pin),
        .o_chip_rst_line_n_o(po), .o_chip_rst_line_n_oe(oe),
        .i_ring_osc_strap(strap[1]), .i_internal_xtal_strap(strap[0]),
        .i_sink_cable_det(cable), .o_core_rst_n(crn), .o_xtal_osc_en(xen),
        .o_standby(sby), .o_core_clk(cclk));
    // ====================
    // Reference model: crystal only when both straps read low
    function automatic logic xtal_of(input int st);
        return st == 0;
    endfunction
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            fails++;
            $display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Bounded wait on the pull-down enable; cnt is cycles spent
    task automatic wait_oe(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (oe !== lvl && cnt < lim) begin
            tick(1);
            cnt++;
        end
    endtask
    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            stop_test();
        end
    end
    // ====================
    // Main sequence
    initial begin
        tick(2);
        @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk_bit(oe, 1'b1);
        chk_bit(po, 1'b0);
        chk_bit(crn, 1'b0);
        chk_bit(xen, 1'b0);
        chk_bit(sby, 1'b0);
        chk_bit(cclk, 1'b0);
        $display("Test reset values done");
        @(posedge clk);
        rail_c <= 1'b1;
        #1;
        wait_oe(1'b0, RC + 20, n);
        chk_rng(n, RC + 2, RC + 6);
        chk_bit(crn, 1'b1);
        $display("Test power-up done");
        // Derived clock toggles every DH cycles
        n = 0;
        pv = cclk;
        repeat (40) begin
            tick(1);
            n += (cclk !== pv);
            pv = cclk;
        end
        chk_rng(n, 40 / DH - 1, 40 / DH + 1);
        $display("Test derived clock done");
        // Short dip of random length must be filtered out
        r = 1 + ($unsigned($random(seed)) % (GLITCH_CYC - 3));
        @(posedge clk);
        rail_c <= 1'b0;
        tick(r);
        @(posedge clk);
        rail_c <= 1'b1;
        #1;
        wait_oe(1'b1, 30, n);
        chk_rng(n, 30, 30);
        chk_bit(oe, 1'b0);
        @(posedge clk);
        rail_c <= 1'b0;
        #1;
        wait_oe(1'b1, 40, n);
        chk_rng(n, GLITCH_CYC, GLITCH_CYC + 6);
        tick(RC);
        chk_bit(crn, 1'b0);
        chk_bit(cclk, 1'b0);
        @(posedge clk);
        rail_c <= 1'b1;
        #1;
        wait_oe(1'b0, RC + 20, n);
        chk_rng(n, RC + 2, RC + 6);
        $display("Test supply droop done");
        // Every strap combination, each behind a manual reset
        r = $unsigned($random(seed)) % 4;
        for (int k = 0; k < 4; k++) begin
            s = (k + r) % 4;
            @(posedge clk);
            strap_c <= s[1:0];
            btn_c <= 1'b1;
            tick(HC - 3);
            @(posedge clk);
            btn_c <= 1'b0;
            #1;
            wait_oe(1'b1, 20, n);
            chk_rng(n, 20, 20);
            chk_bit(oe, 1'b0);
            @(posedge clk);
            btn_c <= 1'b1;
            #1;
            wait_oe(1'b1, HC + 10, n);
            chk_rng(n, HC, HC + 6);
            @(posedge clk);
            btn_c <= 1'b0;
            #1;
            wait_oe(1'b0, RC + 5, n);
            chk_rng(n, RC - 2, RC + 1);
            chk_bit(xen, xtal_of(s));
        end
        $display("Test manual reset and straps done");
        @(posedge clk);
        cable_c <= 1'b0;
        tick(6);
        chk_bit(sby, 1'b1);
        tick(7);
        chk_bit(cclk, 1'b0);
        @(posedge clk);
        cable_c <= 1'b1;
        tick(6);
        chk_bit(sby, 1'b0);
        $display("Test standby done");
        stop_test();
    end
endmodule
